// ### pcb_pkg.sv
// Purpose: Shared constants for the parity checked bus register.
// Assumes: One clock; data bits numbered 1..12 sit at indices 0..11.
// Notes:   Reset values apply to the internal copy of rst_b.
package pcb_pkg;

   localparam int         DATA_W       = 12;
   localparam int         GATED_W      = 8;
   localparam int         PAR_W        = 10;
   localparam int         ERR_LOAD_BIT = 10;
   localparam logic [11:0] STORE_RST   = 12'h000;
   localparam logic       SUM_RST      = 1'h0;
   localparam logic       ERR_IDLE     = 1'h1;
   localparam logic       EVEN_SENSE   = 1'h0;
   localparam logic       OD_LOW       = 1'h0;

   // Fill tracking of the two-stage parity pipeline
   typedef enum logic [1:0]
   {
      PCB_FILL_EMPTY = 2'h0,
      PCB_FILL_HALF  = 2'h1,
      PCB_FILL_READY = 2'h3
   } pcb_fill_e;

   function automatic logic pcb_parity_of(input logic [PAR_W-1:0] bits);
      pcb_parity_of = ^bits;
   endfunction

endpackage

// ### pcb_data_path.sv
// Purpose: Twelve-bit register or buffer path with dual outputs.
// Assumes: Inputs come from logic on clk; rstSync_b is already synchronised.
// Notes:   Storage loads in both modes; only the output select follows mode.
`timescale 1ns/1ps
module pcb_data_path
#(
   parameter int DATA_W  = pcb_pkg::DATA_W,
   parameter int GATED_W = pcb_pkg::GATED_W
)
(
   input  wire logic              clk,
   input  wire logic              rstSync_b,
   input  wire logic [DATA_W-1:0] dataIn,
   input  wire logic              modeSel,
   input  wire logic              clkGate_n,
   output logic      [DATA_W-1:0] dataOut1,
   output logic      [DATA_W-1:0] dataOut2
);

   logic [DATA_W-1:0] store_reg;
   logic [DATA_W-1:0] pathOut;

   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++)
      begin : g_bit
         if (gi < GATED_W)
         begin : g_gated
            always_ff @(posedge clk or negedge rstSync_b)
            begin
               if (!rstSync_b)
                  store_reg[gi] <= pcb_pkg::STORE_RST[gi];
               else if (!clkGate_n)
                  store_reg[gi] <= dataIn[gi];
            end
         end
         else
         begin : g_free
            always_ff @(posedge clk or negedge rstSync_b)
            begin
               if (!rstSync_b)
                  store_reg[gi] <= pcb_pkg::STORE_RST[gi];
               else
                  store_reg[gi] <= dataIn[gi];
            end
         end
      end
   endgenerate

   // Buffer mode bypasses the flops so the pins follow the inputs at once
   assign pathOut  = modeSel ? dataIn : store_reg;
   assign dataOut1 = pathOut;
   assign dataOut2 = pathOut;

endmodule // pcb_data_path

// ### pcb_parity_stage.sv
// Purpose: First parity stage, holding the sum of data bits 1..10.
// Assumes: Late parity arrives one cycle after its data word.
// Notes:   partialSum is valid in the cycle the late parity bit is presented.
`timescale 1ns/1ps
module pcb_parity_stage
#(
   parameter int PAR_W = pcb_pkg::PAR_W
)
(
   input  wire logic             clk,
   input  wire logic             rstSync_b,
   input  wire logic [PAR_W-1:0] dataLow,
   input  wire logic             lateParityIn,
   output logic                  partialSum
);

   logic dataSum_reg;
   logic dataSum_next;

   always_comb
   begin
      dataSum_next = pcb_pkg::pcb_parity_of(dataLow);
   end

   // Advances every edge, clock gate and mode notwithstanding
   always_ff @(posedge clk or negedge rstSync_b)
   begin
      if (!rstSync_b)
         dataSum_reg <= pcb_pkg::SUM_RST;
      else
         dataSum_reg <= dataSum_next;
   end

   assign partialSum = dataSum_reg ^ lateParityIn;

endmodule // pcb_parity_stage

// ### pcb_bus_register.sv
// Purpose: Parity checked twelve-bit bus register with dual float-able outputs.
// Assumes: Upstream logic runs on clk; pins are resolved outside from the enables.
// Notes:   The two-way link pin is split into in, out and enable; the open-drain error pin into out and enable.
//
// Contract
// - Mode select low makes the data path an edge-triggered register.
// - Register mode, clock gate low: all twelve bits load each rising edge.
// - Clock gate high: only bits 9 to 12 load; bits 1 to 8 hold.
// - Mode select high passes inputs straight to outputs, ignoring clock.
// - Each data bit drives two outputs of equal value, twenty-four in all.
// - Float control high floats all data outputs and the error output.
// - Float control never disturbs loading or holding of internal registers.
// - Parity is checked in register mode and in buffer mode alike.
// - Error result appears one cycle after the parity bit, open-drain, low active.
// - Data bit 11 low loads the error register; high forces error output high.
// - Error low when bits 1..10 plus late parity mismatch the parity sense.
// - Parity out enable low drives the partial sum onto the link pin.
// - Parity out enable high floats the link driver and reads the link.
// - Error output counts as valid only once the parity pipeline has filled.
`timescale 1ns/1ps
module pcb_bus_register
#(
   parameter int DATA_W = pcb_pkg::DATA_W
)
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic [DATA_W-1:0] dataIn,
   input  wire logic              lateParityIn,
   input  wire logic              modeSel,
   input  wire logic              clkGate_n,
   input  wire logic              outFloat_n,
   input  wire logic              parityOutEnable,
   input  wire logic              parityLinkIn,
   output logic                   parityLinkOut,
   output logic                   parityLinkOe,
   output logic      [DATA_W-1:0] dataOut1,
   output logic      [DATA_W-1:0] dataOut1Oe,
   output logic      [DATA_W-1:0] dataOut2,
   output logic      [DATA_W-1:0] dataOut2Oe,
   output logic                   parityError_n,
   output logic                   parityErrorOe,
   output logic                   errorValid
);

   logic                    rstMeta_reg;
   logic                    rstSync_reg;
   logic                    rstSync_b;

   logic                    data11ErrorLoadEn;
   logic                    partialSum;
   logic                    paritySense;
   logic                    errLevel_next;
   logic                    errLevel_reg;
   logic                    outDrive;

   pcb_pkg::pcb_fill_e      fill_reg;
   pcb_pkg::pcb_fill_e      fill_next;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMeta_reg <= 1'h0;
         rstSync_reg <= 1'h0;
      end
      else
      begin
         rstMeta_reg <= 1'h1;
         rstSync_reg <= rstMeta_reg;
      end
   end

   assign rstSync_b = rstSync_reg;

   // Data path: register or buffer, dual outputs
   pcb_data_path
   #(
      .DATA_W  (DATA_W),
      .GATED_W (pcb_pkg::GATED_W)
   )
   u_data_path
   (
      .clk       (clk),
      .rstSync_b (rstSync_b),
      .dataIn    (dataIn),
      .modeSel   (modeSel),
      .clkGate_n (clkGate_n),
      .dataOut1  (dataOut1),
      .dataOut2  (dataOut2)
   );

   // Parity taps the raw inputs, so mode select has no say in it
   pcb_parity_stage
   #(
      .PAR_W (pcb_pkg::PAR_W)
   )
   u_parity_stage
   (
      .clk          (clk),
      .rstSync_b    (rstSync_b),
      .dataLow      (dataIn[pcb_pkg::PAR_W-1:0]),
      .lateParityIn (lateParityIn),
      .partialSum   (partialSum)
   );

   assign data11ErrorLoadEn = dataIn[pcb_pkg::ERR_LOAD_BIT];

   // A first cascaded device reads back its own link drive; use even sense then
   always_comb
   begin
      if (parityOutEnable)
         paritySense = parityLinkIn;
      else
         paritySense = pcb_pkg::EVEN_SENSE;
   end

   // Error low when the combined count disagrees with the selected sense
   always_comb
   begin
      if (data11ErrorLoadEn)
         errLevel_next = pcb_pkg::ERR_IDLE;
      else
         errLevel_next = ~(partialSum ^ paritySense);
   end

   always_ff @(posedge clk or negedge rstSync_b)
   begin
      if (!rstSync_b)
         errLevel_reg <= pcb_pkg::ERR_IDLE;
      else
         errLevel_reg <= errLevel_next;
   end

   // Partial sum to the second device of a pair
   assign parityLinkOut = partialSum;
   assign parityLinkOe  = ~parityOutEnable;

   // Float only gates the pin drivers; registers above keep running
   assign outDrive = ~outFloat_n;

   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++)
      begin : g_oe
         assign dataOut1Oe[gi] = outDrive;
         assign dataOut2Oe[gi] = outDrive;
      end
   endgenerate

   // Open drain: only ever pulls low, released otherwise
   assign parityError_n = pcb_pkg::OD_LOW;
   assign parityErrorOe = outDrive & ~errLevel_reg;

   // Two edges after release fill the sum stage and the error stage
   always_comb
   begin
      unique case (fill_reg)
         pcb_pkg::PCB_FILL_EMPTY:
            fill_next = pcb_pkg::PCB_FILL_HALF;
         pcb_pkg::PCB_FILL_HALF:
            fill_next = pcb_pkg::PCB_FILL_READY;
         pcb_pkg::PCB_FILL_READY:
            fill_next = pcb_pkg::PCB_FILL_READY;
         default:
            fill_next = pcb_pkg::PCB_FILL_EMPTY;
      endcase
   end

   always_ff @(posedge clk or negedge rstSync_b)
   begin
      if (!rstSync_b)
         fill_reg <= pcb_pkg::PCB_FILL_EMPTY;
      else
         fill_reg <= fill_next;
   end

   assign errorValid = (fill_reg == pcb_pkg::PCB_FILL_READY);

endmodule // pcb_bus_register

// ### pcb_upstream.sv
// Purpose: Upstream bus logic feeding data and late parity.
// Assumes: Word and its parity are handed over together.
// Notes:   Parity is held back one edge behind its word.
`timescale 1ns/1ps
module pcb_upstream
(
   input  wire logic        clk,
   input  wire logic [11:0] word,
   input  wire logic        par,
   output logic      [11:0] dataIn,
   output logic             lateParityIn = 1'h0
);
   assign dataIn = word;
   always @(posedge clk)
      lateParityIn <= par;
endmodule // pcb_upstream

// ### pcb_bus_register_chk.sv
// Purpose: Port checks for the bus register.
// Assumes: errorValid marks a filled parity pipeline.
// Notes:   Bound to every instance below.
`timescale 1ns/1ps
module pcb_bus_register_chk
#(
   parameter int DATA_W = 12
)
(
   input wire logic              clk,
   input wire logic              rst_b,
   input wire logic [DATA_W-1:0] dataIn,
   input wire logic              lateParityIn,
   input wire logic              modeSel,
   input wire logic              clkGate_n,
   input wire logic              outFloat_n,
   input wire logic              parityOutEnable,
   input wire logic              parityLinkIn,
   input wire logic              parityLinkOut,
   input wire logic              parityLinkOe,
   input wire logic [DATA_W-1:0] dataOut1,
   input wire logic [DATA_W-1:0] dataOut1Oe,
   input wire logic [DATA_W-1:0] dataOut2,
   input wire logic [DATA_W-1:0] dataOut2Oe,
   input wire logic              parityError_n,
   input wire logic              parityErrorOe,
   input wire logic              errorValid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_dual_equal: assert property (dataOut1 == dataOut2)
      else $error("dual outputs differ");
   a_float_data: assert property ((dataOut1Oe | dataOut2Oe) == {DATA_W{!outFloat_n}}
      && (dataOut1Oe & dataOut2Oe) == {DATA_W{!outFloat_n}}) else $error("data enable wrong");
   a_float_err: assert property (outFloat_n |-> !parityErrorOe && !parityError_n)
      else $error("error pin not floated");
   a_buffer_pass: assert property (modeSel |-> dataOut1 == dataIn)
      else $error("buffer path wrong");
   a_full_load: assert property (errorValid && !modeSel && !clkGate_n ##1 !modeSel
      |-> dataOut1 == $past(dataIn)) else $error("full load wrong");
   a_gate_hold: assert property (errorValid && !modeSel && clkGate_n ##1 !modeSel
      |-> dataOut1 == {$past(dataIn[11:8]), $past(dataOut1[7:0])}) else $error("gated load wrong");
   a_err_pipe: assert property (errorValid |-> parityErrorOe == (!outFloat_n
      && !$past(dataIn[10]) && (^$past(dataIn[9:0], 2) ^ $past(lateParityIn)
      ^ ($past(parityOutEnable) & $past(parityLinkIn))))) else $error("error result wrong");
   a_link_sum: assert property (errorValid |-> parityLinkOut
      == (^$past(dataIn[9:0]) ^ lateParityIn)) else $error("link sum wrong");
   a_link_oe: assert property (parityLinkOe == !parityOutEnable)
      else $error("link enable wrong");
   cover property (errorValid && parityErrorOe);
   cover property (errorValid && modeSel && parityErrorOe);
   cover property (!parityOutEnable && parityLinkOut);
endmodule // pcb_bus_register_chk
bind pcb_bus_register pcb_bus_register_chk #(.DATA_W(DATA_W)) chk_u (.clk(clk), .rst_b(rst_b),
   .dataIn(dataIn), .lateParityIn(lateParityIn), .modeSel(modeSel), .clkGate_n(clkGate_n),
   .outFloat_n(outFloat_n), .parityOutEnable(parityOutEnable), .parityLinkIn(parityLinkIn),
   .parityLinkOut(parityLinkOut), .parityLinkOe(parityLinkOe), .dataOut1(dataOut1),
   .dataOut1Oe(dataOut1Oe), .dataOut2(dataOut2), .dataOut2Oe(dataOut2Oe),
   .parityError_n(parityError_n), .parityErrorOe(parityErrorOe), .errorValid(errorValid));

// ### pcb_bus_register_tb.sv
// Purpose: Directed test of the bus register.
// Assumes: Link pin resolved here from the enable.
// Notes:   Expected parity worked out per case.
`timescale 1ns/1ps
module pcb_bus_register_tb;
   logic        clk = 0, rst_b = 0, par = 0, modeSel = 0, clkGate_n = 0;
   logic        outFloat_n = 0, parity_out_enable = 1, senseDrv = 0;
   logic [11:0] word = 12'h000;
   wire  [11:0] dataIn, d1, d1Oe, d2, d2Oe;
   wire         late, linkIn, linkOut, linkOe, errN, errOe, errValid;
   int          err_total = 0, cmp_count = 0, k;
   // Wire level: own drive wins, else the far end
   assign linkIn = linkOe ? linkOut : senseDrv;
   initial forever #2 clk = ~clk;
   pcb_upstream up_u (.clk(clk), .word(word), .par(par), .dataIn(dataIn), .lateParityIn(late));
   pcb_bus_register dut_u (.clk(clk), .rst_b(rst_b), .dataIn(dataIn), .lateParityIn(late),
      .modeSel(modeSel), .clkGate_n(clkGate_n), .outFloat_n(outFloat_n),
      .parityOutEnable(parity_out_enable), .parityLinkIn(linkIn), .parityLinkOut(linkOut),
      .parityLinkOe(linkOe), .dataOut1(d1), .dataOut1Oe(d1Oe), .dataOut2(d2),
      .dataOut2Oe(d2Oe), .parityError_n(errN), .parityErrorOe(errOe), .errorValid(errValid));
   task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task put(input logic [11:0] w, input logic p, input logic g);
      @(posedge clk);
      word <= w;
      par <= p;
      clkGate_n <= g;
   endtask
   task print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_b <= 1;
      for (k = 0; k < 10 && errValid !== 1'h1; k++)
         @(posedge clk);
      chk("fill", 12'h001, {11'h0, errValid});
      if (errValid !== 1'h1)
         print_verdict();
      outFloat_n <= 1;
      put(12'h5A5, 0, 0);
      put(12'hA5A, 0, 1);
      put(12'h000, 0, 1);
      #1;
      chk("gated", 12'hAA5, d1);
      chk("floatOe", 12'h000, d1Oe | d2Oe | errOe);
      @(posedge clk);
      outFloat_n <= 0;
      #1;
      chk("driveOe", 12'hFFF, d1Oe & d2Oe);
      // Edge under float loaded zero into bits 9..12 and kept bits 1..8
      chk("hold2", 12'h0A5, d2);
      $display("test register done");
      @(posedge clk);
      modeSel <= 1;
      word <= 12'h3C3;
      #1;
      chk("buffer", 12'h3C3, d2);
      for (k = 0; k < 8; k++)
      begin
         put(k[2] ? 12'h001 : 12'h003, k[1], 0);
         senseDrv <= k[0];
         modeSel <= k[1];
         put(12'h000, 0, 0);
         put(12'h000, 0, 0);
         #1;
         chk("parity", {11'h0, k[2] ^ k[1] ^ k[0]}, {11'h0, errOe});
      end
      $display("test parity done");
      put(12'h001, 0, 0);
      senseDrv <= 0;
      put(12'h400, 0, 0);
      put(12'h000, 0, 0);
      #1;
      chk("loadOff", 12'h000, {11'h0, errOe});
      put(12'h001, 0, 0);
      parity_out_enable <= 0;
      put(12'h000, 0, 0);
      #1;
      chk("linkOut", 12'h003, {10'h0, linkOe, linkOut});
      put(12'h000, 0, 0);
      #1;
      chk("ownErr", 12'h001, {11'h0, errOe});
      @(posedge clk);
      parity_out_enable <= 1;
      #1;
      chk("linkOff", 12'h000, {11'h0, linkOe});
      $display("test link done");
      print_verdict();
   end
endmodule // pcb_bus_register_tb
